/* File: logic/async_periph_reset_clock_ctrl.sv */
// Reset and clock-gate control bank for peripherals on the async bridge
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defs.svh"

module async_periph_reset_clock_ctrl #(
	// Revision constant; value arbitrary, set per silicon revision
	parameter logic [31:0] REVISION_VALUE = `REVISION_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	output periph_ctrl_pkg::periph_lines_t periph_reset,
	output periph_ctrl_pkg::periph_lines_t periph_clock_en
);

	// Bundled bus request
	periph_ctrl_pkg::bus_req_t req;
	// Decoded register slot
	periph_ctrl_pkg::reg_slot_t slot;
	// Reset control register
	logic [31:0] reset_ctrl_reg;
	logic [31:0] reset_ctrl_next;
	// Clock gate register
	logic [31:0] clock_gate_reg;
	logic [31:0] clock_gate_next;
	// Answer phase flag: request accepted on this cycle
	logic ack_reg;
	// Byte-lane mask from byteenable
	logic [31:0] lane_mask;
	// Read data and response being assembled
	logic [31:0] rdata_next;
	logic [1:0] resp_next;
	// Accept strobes
	logic do_write;
	logic do_read;

	// Pack the bus signals
	always_comb begin
		req.read = avs_read;
		req.write = avs_write;
		req.address = avs_address;
		req.writedata = avs_writedata;
		req.byteenable = avs_byteenable;
	end

	// Address decoder
	addr_decode u_decode (
		.address(req.address),
		.slot(slot)
	);

	// Expand byte enables to a bit mask
	always_comb begin
		lane_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
			{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
	end

	// Each request waits one cycle, then completes on the ack cycle
	always_comb begin
		avs_waitrequest = (req.read | req.write) & ~ack_reg;
		do_write = req.write & ack_reg;
		do_read = req.read & ack_reg;
	end

	// Ack toggles high for one cycle per request
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (req.read | req.write) & ~ack_reg;
		end
	end

	// Next value of the reset control register
	always_comb begin
		reset_ctrl_next = reset_ctrl_reg;
		case (slot)
			periph_ctrl_pkg::SLOT_RESET_CTRL: begin
				reset_ctrl_next = (reset_ctrl_reg & ~lane_mask)
					| (req.writedata & lane_mask);
			end
			periph_ctrl_pkg::SLOT_RESET_SET: begin
				reset_ctrl_next = reset_ctrl_reg
					| (req.writedata & lane_mask);
			end
			periph_ctrl_pkg::SLOT_RESET_CLEAR: begin
				reset_ctrl_next = reset_ctrl_reg
					& ~(req.writedata & lane_mask);
			end
			default: begin
				reset_ctrl_next = reset_ctrl_reg;
			end
		endcase
		reset_ctrl_next = reset_ctrl_next & `PERIPH_MASK;
	end

	// Reset control register update
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reset_ctrl_reg <= `PERIPH_RESET_VALUE;
		end else if (do_write) begin
			reset_ctrl_reg <= reset_ctrl_next;
		end
	end

	// Next value of the clock gate register
	always_comb begin
		if (slot == periph_ctrl_pkg::SLOT_CLOCK_GATE) begin
			clock_gate_next = ((clock_gate_reg & ~lane_mask)
				| (req.writedata & lane_mask)) & `PERIPH_MASK;
		end else begin
			clock_gate_next = clock_gate_reg;
		end
	end

	// Clock gate register update
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			clock_gate_reg <= `PERIPH_RESET_VALUE;
		end else if (do_write) begin
			clock_gate_reg <= clock_gate_next;
		end
	end

	// Read mux; aliases read zero and unmapped addresses answer decode error
	always_comb begin
		rdata_next = 32'h00000000;
		resp_next = 2'h0;
		case (slot)
			periph_ctrl_pkg::SLOT_REVISION: begin
				rdata_next = REVISION_VALUE;
			end
			periph_ctrl_pkg::SLOT_RESET_CTRL: begin
				rdata_next = reset_ctrl_reg;
			end
			periph_ctrl_pkg::SLOT_RESET_SET,
			periph_ctrl_pkg::SLOT_RESET_CLEAR: begin
				rdata_next = 32'h00000000;
			end
			periph_ctrl_pkg::SLOT_CLOCK_GATE: begin
				rdata_next = clock_gate_reg;
			end
			default: begin
				resp_next = 2'h3;
			end
		endcase
	end

	// Registered read data, presented during the ack cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			avs_readdata <= 32'h00000000;
			avs_response <= 2'h0;
		end else if ((req.read | req.write) & ~ack_reg) begin
			avs_readdata <= req.read ? rdata_next : 32'h00000000;
			avs_response <= resp_next;
		end
	end

	line_fanout u_reset_lines (
		.value(reset_ctrl_reg),
		.lines(periph_reset)
	);

	// bit 15 drives the rate generator gate
	line_fanout u_clock_lines (
		.value(clock_gate_reg),
		.lines(periph_clock_en)
	);

	a_reset_follows: assert property (@(posedge clk_sys) disable iff (srst)
		periph_reset.timer_a == reset_ctrl_reg[`BIT_TIMER_A])
		else $error("timer reset line mismatch");

	a_set_alias: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot == periph_ctrl_pkg::SLOT_RESET_SET
		&& avs_byteenable == 4'hF |=> (reset_ctrl_reg
		== (($past(reset_ctrl_reg) | $past(avs_writedata)) & `PERIPH_MASK)))
		else $error("set alias wrong");

	a_clear_alias: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot == periph_ctrl_pkg::SLOT_RESET_CLEAR
		&& avs_byteenable == 4'hF |=> (reset_ctrl_reg
		== ($past(reset_ctrl_reg) & ~$past(avs_writedata))))
		else $error("clear alias wrong");

	a_alias_no_state: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot != periph_ctrl_pkg::SLOT_CLOCK_GATE
		|=> $stable(clock_gate_reg))
		else $error("clock gate changed by other write");

	a_bit_map: assert property (@(posedge clk_sys) disable iff (srst)
		((reset_ctrl_reg | clock_gate_reg) & ~`PERIPH_MASK) == 32'h0)
		else $error("unimplemented bit set");

	a_clock_write: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot == periph_ctrl_pkg::SLOT_CLOCK_GATE
		&& avs_byteenable == 4'hF
		|=> periph_clock_en.fractional_rate_generator
		== $past(avs_writedata[`BIT_RATE_GEN]))
		else $error("rate generator gate wrong");

	a_reset_zero: assert property (@(posedge clk_sys)
		$past(srst) |-> reset_ctrl_reg == 32'h0 && clock_gate_reg == 32'h0)
		else $error("not zero after reset");

	a_revision_read: assert property (@(posedge clk_sys) disable iff (srst)
		avs_read && !ack_reg && slot == periph_ctrl_pkg::SLOT_REVISION
		##1 avs_read |-> avs_readdata == REVISION_VALUE
		&& !avs_waitrequest)
		else $error("revision read wrong");

	// every reset line follows its control bit
	a_reset_lines_all: assert property (@(posedge clk_sys) disable iff (srst)
		periph_reset == {reset_ctrl_reg[4:1], reset_ctrl_reg[7:5],
		reset_ctrl_reg[10:9], reset_ctrl_reg[13], reset_ctrl_reg[14],
		reset_ctrl_reg[15]})
		else $error("reset lines mismatch");

	// every clock line follows its gate bit
	a_clock_lines_all: assert property (@(posedge clk_sys) disable iff (srst)
		periph_clock_en == {clock_gate_reg[4:1], clock_gate_reg[7:5],
		clock_gate_reg[10:9], clock_gate_reg[13], clock_gate_reg[14],
		clock_gate_reg[15]})
		else $error("clock lines mismatch");

	// direct write of the reset register
	a_ctrl_write: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot == periph_ctrl_pkg::SLOT_RESET_CTRL
		&& avs_byteenable == 4'hF
		|=> reset_ctrl_reg == ($past(avs_writedata) & `PERIPH_MASK))
		else $error("reset register write wrong");

	a_set_lanes: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot == periph_ctrl_pkg::SLOT_RESET_SET
		|=> reset_ctrl_reg == (($past(reset_ctrl_reg)
		| ($past(avs_writedata) & $past(lane_mask))) & `PERIPH_MASK))
		else $error("set alias lanes wrong");

	a_clear_lanes: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot == periph_ctrl_pkg::SLOT_RESET_CLEAR
		|=> reset_ctrl_reg == ($past(reset_ctrl_reg)
		& ~($past(avs_writedata) & $past(lane_mask))))
		else $error("clear alias lanes wrong");

	// clock gate write honours byte lanes
	a_gate_lanes: assert property (@(posedge clk_sys) disable iff (srst)
		do_write && slot == periph_ctrl_pkg::SLOT_CLOCK_GATE
		|=> clock_gate_reg == ((($past(clock_gate_reg) & ~$past(lane_mask))
		| ($past(avs_writedata) & $past(lane_mask))) & `PERIPH_MASK))
		else $error("clock gate lanes wrong");

	// nothing but a write changes the reset register
	a_ctrl_hold: assert property (@(posedge clk_sys) disable iff (srst)
		!do_write |=> $stable(reset_ctrl_reg))
		else $error("reset register changed without write");

	a_alias_read_zero: assert property (@(posedge clk_sys) disable iff (srst)
		do_read && (slot == periph_ctrl_pkg::SLOT_RESET_SET
		|| slot == periph_ctrl_pkg::SLOT_RESET_CLEAR)
		|-> avs_readdata == 32'h00000000 && avs_response == 2'h0)
		else $error("alias read not zero");

	a_unmapped_error: assert property (@(posedge clk_sys) disable iff (srst)
		do_read && slot == periph_ctrl_pkg::SLOT_NONE
		|-> avs_response == 2'h3 && avs_readdata == 32'h00000000)
		else $error("unmapped read not refused");

	// revision read answers the constant with OKAY
	a_revision_value: assert property (@(posedge clk_sys) disable iff (srst)
		do_read && slot == periph_ctrl_pkg::SLOT_REVISION
		|-> avs_readdata == REVISION_VALUE && avs_response == 2'h0)
		else $error("revision value wrong");

	a_reserved_read: assert property (@(posedge clk_sys) disable iff (srst)
		do_read && slot == periph_ctrl_pkg::SLOT_CLOCK_GATE
		|-> (avs_readdata & ~`PERIPH_MASK) == 32'h00000000)
		else $error("reserved clock bits not zero");

	// a fresh request waits exactly one cycle
	a_wait_one: assert property (@(posedge clk_sys) disable iff (srst)
		(avs_read || avs_write) && !ack_reg
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("wait state count wrong");

	a_idle_no_wait: assert property (@(posedge clk_sys) disable iff (srst)
		!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("waitrequest high while idle");

	a_two_wire_zero: assert property (@(posedge clk_sys)
		$past(srst) |-> periph_reset.two_wire == 3'h0
		&& periph_clock_en.two_wire == 3'h0)
		else $error("two-wire lines not zero after reset");

endmodule : async_periph_reset_clock_ctrl
`default_nettype wire

/* File: shared/periph_ctrl_defs.svh */
// Offsets, field positions, reset values and masks of the peripheral control bank
`ifndef PERIPH_CTRL_DEFS_SVH
`define PERIPH_CTRL_DEFS_SVH

// Byte addresses of the registers
`define ADDR_REVISION_ID 32'h400003FC
`define ADDR_RESET_CTRL 32'h40080000
`define ADDR_RESET_SET 32'h40080004
`define ADDR_RESET_CLEAR 32'h40080008
`define ADDR_CLOCK_GATE 32'h40080010

// Bit positions shared by the reset and clock-gate registers
`define BIT_SERIAL0 1
`define BIT_SERIAL1 2
`define BIT_SERIAL2 3
`define BIT_SERIAL3 4
`define BIT_TWO_WIRE0 5
`define BIT_TWO_WIRE1 6
`define BIT_TWO_WIRE2 7
`define BIT_SPI0 9
`define BIT_SPI1 10
`define BIT_TIMER_A 13
`define BIT_TIMER_B 14
`define BIT_RATE_GEN 15

// Implemented bits: 1..7, 9, 10, 13..15
`define PERIPH_MASK 32'h0000E6FE

// Reset value of both control registers
`define PERIPH_RESET_VALUE 32'h00000000

// Neutral revision value; arbitrary, not taken from any real part
`define REVISION_DEFAULT 32'h00A5_0001

`endif

/* File: shared/periph_ctrl_pkg.sv */
// Types used by the peripheral control bank
package periph_ctrl_pkg;

	// Register slots decoded from the bus address
	typedef enum logic [2:0] {
		SLOT_NONE,
		SLOT_REVISION,
		SLOT_RESET_CTRL,
		SLOT_RESET_SET,
		SLOT_RESET_CLEAR,
		SLOT_CLOCK_GATE
	} reg_slot_t;

	// One bus request as seen by the bank
	typedef struct packed {
		logic read;
		logic write;
		logic [31:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} bus_req_t;

	// Per-peripheral control lines
	typedef struct packed {
		logic [3:0] serial;
		logic [2:0] two_wire;
		logic [1:0] spi;
		logic timer_a;
		logic timer_b;
		logic fractional_rate_generator;
	} periph_lines_t;

endpackage : periph_ctrl_pkg

/* File: logic/addr_decode.sv */
// Address decoder mapping bus addresses to register slots
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defs.svh"

module addr_decode (
	input wire logic [31:0] address,
	output periph_ctrl_pkg::reg_slot_t slot
);

	// Compare the full byte address against each register
	always_comb begin
		case (address)
			`ADDR_REVISION_ID: slot = periph_ctrl_pkg::SLOT_REVISION;
			`ADDR_RESET_CTRL: slot = periph_ctrl_pkg::SLOT_RESET_CTRL;
			`ADDR_RESET_SET: slot = periph_ctrl_pkg::SLOT_RESET_SET;
			`ADDR_RESET_CLEAR: slot = periph_ctrl_pkg::SLOT_RESET_CLEAR;
			`ADDR_CLOCK_GATE: slot = periph_ctrl_pkg::SLOT_CLOCK_GATE;
			default: slot = periph_ctrl_pkg::SLOT_NONE;
		endcase
	end

endmodule : addr_decode
`default_nettype wire

/* File: logic/line_fanout.sv */
// Unpacks a control register into per-peripheral lines
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defs.svh"

module line_fanout (
	input wire logic [31:0] value,
	output periph_ctrl_pkg::periph_lines_t lines
);

	// Each peripheral takes its own fixed bit
	always_comb begin
		lines.serial = value[`BIT_SERIAL3:`BIT_SERIAL0];
		lines.two_wire = value[`BIT_TWO_WIRE2:`BIT_TWO_WIRE0];
		lines.spi = value[`BIT_SPI1:`BIT_SPI0];
		lines.timer_a = value[`BIT_TIMER_A];
		lines.timer_b = value[`BIT_TIMER_B];
		lines.fractional_rate_generator = value[`BIT_RATE_GEN];
	end

endmodule : line_fanout
`default_nettype wire

/* File: tb/periph_model.sv */
// Behavioural model of the peripherals fed by the reset and clock lines
`timescale 1ns/1ps
`default_nettype none

module periph_model (
	input wire logic clk_sys,
	input wire periph_ctrl_pkg::periph_lines_t periph_reset,
	input wire periph_ctrl_pkg::periph_lines_t periph_clock_en,
	output logic [11:0] running
);
	// run when clocked, out of reset
	always_ff @(posedge clk_sys) begin
		running <= periph_clock_en & ~periph_reset;
	end
endmodule : periph_model

`default_nettype wire

/* File: tb/tb_async_periph_reset_clock_ctrl.sv */
// Register tests for the peripheral reset and clock-gate bank
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defs.svh"

module tb_async_periph_reset_clock_ctrl;
	// Arbitrary revision value, differs from the default
	localparam logic [31:0] REV = 32'h00A5_0002;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [31:0] avs_address = 32'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] avs_response;
	periph_ctrl_pkg::periph_lines_t periph_reset;
	periph_ctrl_pkg::periph_lines_t periph_clock_en;
	logic [11:0] running;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic [1:0] rsp;
	int pos [12] = '{1, 2, 3, 4, 5, 6, 7, 9, 10, 13, 14, 15};

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	async_periph_reset_clock_ctrl #(.REVISION_VALUE(REV)) u_dut (
		.clk_sys(clk_sys),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response),
		.periph_reset(periph_reset),
		.periph_clock_en(periph_clock_en)
	);

	periph_model u_model (
		.clk_sys(clk_sys),
		.periph_reset(periph_reset),
		.periph_clock_en(periph_clock_en),
		.running(running)
	);

	// Prints counts and verdict, ends the run
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	// Compares one value and counts it
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Waits for waitrequest low, takes the answer, releases
	task automatic bus_wait();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			chk(32'h1, 32'h0);
		end
		rd = avs_readdata;
		rsp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus_wait

	// Avalon write with byte enables
	task automatic wr(input logic [31:0] a, d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		bus_wait();
	endtask : wr

	// Avalon read, result in rd and rsp
	task automatic rdr(input logic [31:0] a);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		bus_wait();
	endtask : rdr

	// Expected line struct for a register value
	function automatic logic [11:0] lines_of(input logic [31:0] v);
		return {v[4:1], v[7:5], v[10:9], v[13], v[14], v[15]};
	endfunction : lines_of

	// Main test sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		rdr(`ADDR_RESET_CTRL);
		chk(rd, 32'h0);
		rdr(`ADDR_CLOCK_GATE);
		chk(rd, 32'h0);
		chk({periph_reset, periph_clock_en}, 32'h0);
		wr(`ADDR_RESET_CTRL, 32'hFFFFFFFF, 4'hF);
		@(posedge clk_sys);
		chk(periph_reset, lines_of(`PERIPH_MASK));
		rdr(`ADDR_RESET_CTRL);
		chk(rd, `PERIPH_MASK);
		wr(`ADDR_RESET_CLEAR, 32'h00000006, 4'hF);
		rdr(`ADDR_RESET_CTRL);
		chk(rd, 32'h0000E6F8);
		wr(`ADDR_RESET_CTRL, 32'h0, 4'hF);
		wr(`ADDR_RESET_SET, 32'h00008002, 4'hF);
		wr(`ADDR_RESET_SET, 32'h00000004, 4'hF);
		rdr(`ADDR_RESET_CTRL);
		chk(rd, 32'h00008006);
		chk(periph_reset, lines_of(32'h00008006));
		rdr(`ADDR_RESET_SET);
		chk({rsp, rd}, 34'h0);
		// Walk one enable bit through every peripheral
		for (int i = 0; i < 12; i++) begin
			wr(`ADDR_CLOCK_GATE, 32'h1 << pos[i], 4'hF);
			@(posedge clk_sys);
			chk(periph_clock_en, lines_of(32'h1 << pos[i]));
			@(posedge clk_sys);
			chk(running, lines_of(32'h1 << pos[i]) & ~lines_of(32'h8006));
		end
		wr(`ADDR_CLOCK_GATE, 32'hFFFFFFFF, 4'hF);
		rdr(`ADDR_CLOCK_GATE);
		chk(rd, `PERIPH_MASK);
		wr(`ADDR_RESET_CTRL, 32'hFFFFFFFF, 4'h2);
		rdr(`ADDR_RESET_CTRL);
		chk(rd, 32'h0000E606);
		wr(`ADDR_REVISION_ID, 32'h0, 4'hF);
		rdr(`ADDR_REVISION_ID);
		chk({rsp, rd}, {2'b00, REV});
		rdr(32'h40080020);
		chk({rsp, rd}, {2'b11, 32'h0});
		// Mid-run reset clears both registers again
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		rdr(`ADDR_RESET_CTRL);
		chk({rsp, rd}, 34'h0);
		rdr(`ADDR_CLOCK_GATE);
		chk(rd, 32'h0);
		// Byte lanes limit the set and clear aliases
		wr(`ADDR_RESET_SET, 32'h0000FFFE, 4'h1);
		rdr(`ADDR_RESET_CTRL);
		chk(rd, 32'h000000FE);
		wr(`ADDR_RESET_CLEAR, 32'h0000E6FE, 4'h2);
		wr(`ADDR_RESET_CLEAR, 32'h00000006, 4'h1);
		rdr(`ADDR_RESET_CTRL);
		chk(rd, 32'h000000F8);
		give_verdict();
	end

	// Watchdog cuts a hung run short
	initial begin
		#10000;
		err_count++;
		give_verdict();
	end
endmodule : tb_async_periph_reset_clock_ctrl

`default_nettype wire
